// >>> srev_top.sv
// Signal notification and reservation lost event latching with APB register access
// Functional notes
// - signal two count going empty to valid raises its event.
// - signal one count going empty to valid raises its event.
// - any event sets its pending bit regardless of mask.
// - enabled event also sets status bit and status count to one.
// - acknowledge write with a bit at one clears that pending bit.
// - privileged pending write with a bit at zero clears that bit.
// - after signal event the channel reads immediately, no stall.
// - reserve command establishes a reservation on the line.
// - outside modification of the reserved line drops it, raising reservation lost.
// - purge bit written one drops the reservation, raising reservation lost.
`timescale 1ns/1ps
`include "srev_regs.svh"

module srev_top
(
  input  wire logic          mclk_in,
  input  wire logic          rst_b_in,
  input  wire logic          psel_in,
  input  wire logic          penable_in,
  input  wire logic          pwrite_in,
  input  wire logic [11:0]   paddr_in,
  input  wire logic [31:0]   pwdata_in,
  output logic [31:0]        prdata_out,
  output logic               pready_out,
  output logic               pslverr_out,
  input  wire logic          sig_one_wr_in,
  input  wire logic [31:0]   sig_one_data_in,
  input  wire logic          sig_two_wr_in,
  input  wire logic [31:0]   sig_two_data_in,
  input  wire logic          reserve_in,
  input  wire logic [24:0]   reserve_line_in,
  input  wire logic          snoop_mod_in,
  input  wire logic [24:0]   snoop_line_in,
  output logic               event_status_count_out,
  output logic [2:0]         event_mask_readback_out,
  output logic               irq_out
);

  typedef struct packed {
    srev_pkg::srev_ev_t     pending;
    srev_pkg::srev_ev_t     mask;
    srev_pkg::srev_ev_t     status;
    logic                   stat_cnt;
    srev_pkg::srev_ev_t     irq_stat;
    srev_pkg::srev_ev_t     irq_mask;
    logic [31:0]            rdata;
    srev_pkg::srev_apb_st_t apb;
    logic                   slverr;
  } srev_state_t;

  srev_state_t          state_ff;
  srev_state_t          nxt_state;
  srev_pkg::srev_sig_t  sig_one;
  srev_pkg::srev_sig_t  sig_two;
  srev_pkg::srev_resv_t resv;
  logic                 one_avail;
  logic                 two_avail;
  logic                 resv_lost;
  logic                 access;
  logic                 wr_acc;
  logic                 rd_acc;
  logic                 purge;
  srev_pkg::srev_ev_t   events;
  srev_pkg::srev_ev_t   ack_clr;
  srev_pkg::srev_ev_t   priv_clr;

  // True when the address equals the given offset; callers qualify it with the access
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = (addr == off);
  endfunction

  function automatic logic [31:0] pad_ev(input srev_pkg::srev_ev_t v);
    pad_ev = {29'h0000_0000, v};
  endfunction

  // The slave answers in the first access cycle, so no wait states
  assign access  = psel_in && penable_in && (state_ff.apb == srev_pkg::SREV_ACCESS);
  assign wr_acc  = access && pwrite_in;
  assign rd_acc  = access && !pwrite_in;
  assign purge   = wr_acc && hit(paddr_in, `SREV_OFF_PURGE) && pwdata_in[`SREV_BIT_PURGE];

  srev_sig_chan u_sig_one
  (
    .mclk_in         (mclk_in),
    .rst_b_in        (rst_b_in),
    .wr_in           (sig_one_wr_in),
    .wdata_in        (sig_one_data_in),
    .rd_in           (rd_acc && hit(paddr_in, `SREV_OFF_SIG_ONE) && sig_one.valid),
    .chan_out        (sig_one),
    .avail_pulse_out (one_avail)
  );

  srev_sig_chan u_sig_two
  (
    .mclk_in         (mclk_in),
    .rst_b_in        (rst_b_in),
    .wr_in           (sig_two_wr_in),
    .wdata_in        (sig_two_data_in),
    .rd_in           (rd_acc && hit(paddr_in, `SREV_OFF_SIG_TWO) && sig_two.valid),
    .chan_out        (sig_two),
    .avail_pulse_out (two_avail)
  );

  srev_resv u_resv
  (
    .mclk_in         (mclk_in),
    .rst_b_in        (rst_b_in),
    .reserve_in      (reserve_in),
    .reserve_line_in (reserve_line_in),
    .snoop_mod_in    (snoop_mod_in),
    .snoop_line_in   (snoop_line_in),
    .purge_in        (purge),
    .resv_out        (resv),
    .lost_pulse_out  (resv_lost)
  );

  always_comb
  begin
    events                    = `SREV_RST_EV;
    events[`SREV_BIT_S2]      = two_avail;
    events[`SREV_BIT_S1]      = one_avail;
    events[`SREV_BIT_LR]      = resv_lost;
    ack_clr  = (wr_acc && hit(paddr_in, `SREV_OFF_ACK)) ? pwdata_in[2:0] : `SREV_RST_EV;
    priv_clr = (wr_acc && hit(paddr_in, `SREV_OFF_PENDING)) ? ~pwdata_in[2:0] : `SREV_RST_EV;
  end

  always_comb
  begin
    nxt_state = state_ff;
    // Per-bit vectors keep every source independent; a new event wins over a same-cycle clear
    nxt_state.pending = (state_ff.pending & ~ack_clr & ~priv_clr) | events;
    nxt_state.status  = state_ff.status | (events & state_ff.mask);
    if ((events & state_ff.mask) != `SREV_RST_EV)
    begin
      nxt_state.stat_cnt = 1'b1;
    end
    nxt_state.irq_stat = state_ff.irq_stat | events;

    unique case (state_ff.apb)
      srev_pkg::SREV_IDLE:
      begin
        if (psel_in && !penable_in)
        begin
          nxt_state.apb = srev_pkg::SREV_ACCESS;
        end
      end
      srev_pkg::SREV_ACCESS:
      begin
        if (access)
        begin
          nxt_state.apb = srev_pkg::SREV_DONE;
        end
      end
      srev_pkg::SREV_DONE:
      begin
        nxt_state.apb = (psel_in && !penable_in) ? srev_pkg::SREV_ACCESS : srev_pkg::SREV_IDLE;
      end
      default:
      begin
        nxt_state.apb = srev_pkg::SREV_IDLE;
      end
    endcase

    if (access)
    begin
      nxt_state.slverr = 1'b0;
      nxt_state.rdata  = `SREV_RST_WORD;
      unique case (paddr_in)
        `SREV_OFF_PENDING:  nxt_state.rdata = pad_ev(state_ff.pending);
        `SREV_OFF_MASK:
        begin
          nxt_state.rdata = pad_ev(state_ff.mask);
          if (pwrite_in)
          begin
            nxt_state.mask = pwdata_in[2:0];
          end
        end
        `SREV_OFF_STATUS:
        begin
          nxt_state.rdata = {state_ff.stat_cnt, 28'h000_0000, state_ff.status};
          // Reading status consumes it; an event in this cycle is kept
          if (!pwrite_in)
          begin
            nxt_state.status   = events & state_ff.mask;
            nxt_state.stat_cnt = ((events & state_ff.mask) != `SREV_RST_EV);
          end
        end
        `SREV_OFF_ACK:      nxt_state.rdata = `SREV_RST_WORD;
        `SREV_OFF_SIG_ONE:  nxt_state.rdata = sig_one.data;
        `SREV_OFF_SIG_TWO:  nxt_state.rdata = sig_two.data;
        `SREV_OFF_RESV:     nxt_state.rdata = {resv.valid, 6'h00, resv.line};
        `SREV_OFF_PURGE:    nxt_state.rdata = `SREV_RST_WORD;
        `SREV_OFF_IRQ_STAT:
        begin
          nxt_state.rdata = pad_ev(state_ff.irq_stat);
          if (!pwrite_in)
          begin
            nxt_state.irq_stat = events;
          end
        end
        `SREV_OFF_IRQ_MASK:
        begin
          nxt_state.rdata = pad_ev(state_ff.irq_mask);
          if (pwrite_in)
          begin
            nxt_state.irq_mask = pwdata_in[2:0];
          end
        end
        default:            nxt_state.slverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      state_ff     <= '0;
      state_ff.apb <= srev_pkg::SREV_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Read data is taken from flops one cycle after the access edge would be too late,
  // so the combinational value is forwarded during the access cycle itself
  always_comb
  begin
    prdata_out  = `SREV_RST_WORD;
    pslverr_out = 1'b0;
    if (access)
    begin
      unique case (paddr_in)
        `SREV_OFF_PENDING:  prdata_out = pad_ev(state_ff.pending);
        `SREV_OFF_MASK:     prdata_out = pad_ev(state_ff.mask);
        `SREV_OFF_STATUS:   prdata_out = {state_ff.stat_cnt, 28'h000_0000, state_ff.status};
        `SREV_OFF_SIG_ONE:  prdata_out = sig_one.data;
        `SREV_OFF_SIG_TWO:  prdata_out = sig_two.data;
        `SREV_OFF_RESV:     prdata_out = {resv.valid, 6'h00, resv.line};
        `SREV_OFF_IRQ_STAT: prdata_out = pad_ev(state_ff.irq_stat);
        `SREV_OFF_IRQ_MASK: prdata_out = pad_ev(state_ff.irq_mask);
        `SREV_OFF_ACK,
        `SREV_OFF_PURGE:    prdata_out = `SREV_RST_WORD;
        default:            pslverr_out = 1'b1;
      endcase
    end
  end

  assign pready_out              = access;
  assign event_status_count_out  = state_ff.stat_cnt;
  assign event_mask_readback_out = state_ff.mask;
  assign irq_out                 = |(state_ff.irq_stat & state_ff.irq_mask);

endmodule // srev_top

// >>> srev_regs.svh
// Register offsets, field positions and reset values of the signal and reservation event block
`ifndef SREV_REGS_SVH
`define SREV_REGS_SVH

`define SREV_OFF_PENDING    12'h000
`define SREV_OFF_MASK       12'h004
`define SREV_OFF_STATUS     12'h008
`define SREV_OFF_ACK        12'h00C
`define SREV_OFF_SIG_ONE    12'h010
`define SREV_OFF_SIG_TWO    12'h014
`define SREV_OFF_RESV       12'h018
`define SREV_OFF_PURGE      12'h01C
`define SREV_OFF_IRQ_STAT   12'h020
`define SREV_OFF_IRQ_MASK   12'h024

`define SREV_BIT_LR         0
`define SREV_BIT_S1         1
`define SREV_BIT_S2         2
`define SREV_NUM_EV         3

`define SREV_BIT_PURGE      0
`define SREV_BIT_RESV_VALID 31
`define SREV_BIT_CNT        31
`define SREV_LINE_W         25

`define SREV_RST_EV         3'h0
`define SREV_RST_WORD       32'h0000_0000
`define SREV_ONE_EV         3'h1

`endif

// >>> srev_pkg.sv
// Types shared by the signal and reservation event block
package srev_pkg;

  typedef logic [2:0] srev_ev_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } srev_sig_t;

  typedef struct packed {
    logic        valid;
    logic [24:0] line;
  } srev_resv_t;

  typedef enum logic [2:0] {
    SREV_IDLE   = 3'b001,
    SREV_ACCESS = 3'b010,
    SREV_DONE   = 3'b100
  } srev_apb_st_t;

endpackage

// >>> srev_sig_chan.sv
// One signal notification channel: holds a word written from outside and flags empty-to-valid
`timescale 1ns/1ps
`include "srev_regs.svh"

module srev_sig_chan
(
  input  wire logic             mclk_in,
  input  wire logic             rst_b_in,
  input  wire logic             wr_in,
  input  wire logic [31:0]      wdata_in,
  input  wire logic             rd_in,
  output srev_pkg::srev_sig_t   chan_out,
  output logic                  avail_pulse_out
);

  typedef struct packed {
    srev_pkg::srev_sig_t sig;
    logic                avail;
  } srev_sc_state_t;

  srev_sc_state_t state_ff;
  srev_sc_state_t nxt_state;

  always_comb
  begin
    nxt_state       = state_ff;
    nxt_state.avail = 1'b0;
    if (rd_in)
    begin
      nxt_state.sig.valid = 1'b0;
    end
    // A write while still valid ORs in, count stays 1 and no new event fires
    if (wr_in)
    begin
      nxt_state.sig.data  = (state_ff.sig.valid && !rd_in) ? (state_ff.sig.data | wdata_in) : wdata_in;
      nxt_state.sig.valid = 1'b1;
      nxt_state.avail     = !state_ff.sig.valid || rd_in;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign chan_out        = state_ff.sig;
  assign avail_pulse_out = state_ff.avail;

endmodule // srev_sig_chan

// >>> srev_resv.sv
// Lock-line reservation tracker: set by reserve, dropped by snoop hit or purge
`timescale 1ns/1ps
`include "srev_regs.svh"

module srev_resv
(
  input  wire logic               mclk_in,
  input  wire logic               rst_b_in,
  input  wire logic               reserve_in,
  input  wire logic [24:0]        reserve_line_in,
  input  wire logic               snoop_mod_in,
  input  wire logic [24:0]        snoop_line_in,
  input  wire logic               purge_in,
  output srev_pkg::srev_resv_t    resv_out,
  output logic                    lost_pulse_out
);

  typedef struct packed {
    srev_pkg::srev_resv_t resv;
    logic                 lost;
  } srev_rs_state_t;

  srev_rs_state_t state_ff;
  srev_rs_state_t nxt_state;
  logic           drop;

  always_comb
  begin
    nxt_state      = state_ff;
    nxt_state.lost = 1'b0;
    drop           = state_ff.resv.valid &&
                     ((snoop_mod_in && (snoop_line_in == state_ff.resv.line)) || purge_in);
    if (drop)
    begin
      nxt_state.resv.valid = 1'b0;
      nxt_state.lost       = 1'b1;
    end
    // A reserve in the same cycle wins: the program asked for the line afresh
    if (reserve_in)
    begin
      nxt_state.resv.valid = 1'b1;
      nxt_state.resv.line  = reserve_line_in;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign resv_out       = state_ff.resv;
  assign lost_pulse_out = state_ff.lost;

endmodule // srev_resv

// >>> srev_top_chk.sv
// Port-level checker for the signal and reservation event block
`timescale 1ns/1ps
module srev_top_chk
(
  input wire logic        mclk_in,
  input wire logic        rst_b_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        sig_one_wr_in,
  input wire logic        sig_two_wr_in,
  input wire logic        reserve_in,
  input wire logic [24:0] reserve_line_in,
  input wire logic        snoop_mod_in,
  input wire logic [24:0] snoop_line_in,
  input wire logic        event_status_count_out,
  input wire logic [2:0]  event_mask_readback_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);
  logic        acc, rd1, rd2, drop;
  logic        v1_ff, v2_ff, rv_ff;
  logic [24:0] rl_ff;
  assign acc = psel_in && penable_in;
  assign rd1 = acc && !pwrite_in && paddr_in == 12'h010;
  assign rd2 = acc && !pwrite_in && paddr_in == 12'h014;
  // Purge or a matching snoop only counts while a reservation is held
  assign drop = rv_ff && ((acc && pwrite_in && paddr_in == 12'h01C && pwdata_in[0])
                || (snoop_mod_in && snoop_line_in == rl_ff));
  always_ff @(posedge mclk_in)
  begin
    if (!rst_b_in)
    begin
      v1_ff <= 1'b0;
      v2_ff <= 1'b0;
      rv_ff <= 1'b0;
      rl_ff <= 25'h000_0000;
    end
    else
    begin
      v1_ff <= sig_one_wr_in || (v1_ff && !rd1);
      v2_ff <= sig_two_wr_in || (v2_ff && !rd2);
      // A reserve in the cycle of a drop keeps the reservation
      rv_ff <= reserve_in || (rv_ff && !drop);
      rl_ff <= reserve_in ? reserve_line_in : rl_ff;
    end
  end
  chk_ready_now: assert property (acc |-> pready_out)
    else $error("no ready in access cycle");
  chk_err_reads_zero: assert property (acc && pslverr_out |-> prdata_out == 32'h0000_0000 || pwrite_in)
    else $error("refused read returned data");
  chk_no_stall: assert property (rd1 || rd2 |-> pready_out && !pslverr_out)
    else $error("signal channel read stalled");
  chk_mask_write: assert property (acc && pwrite_in && paddr_in == 12'h004
    |=> event_mask_readback_out == $past(pwdata_in[2:0])) else $error("mask not written");
  chk_status_bit: assert property (acc && !pwrite_in && paddr_in == 12'h008
    |-> prdata_out[31] == event_status_count_out) else $error("count bit differs");
  chk_sig_one_stat: assert property (sig_one_wr_in && !v1_ff && event_mask_readback_out[1]
    |-> ##[2:3] event_status_count_out) else $error("signal one event lost");
  chk_sig_two_stat: assert property (sig_two_wr_in && !v2_ff && event_mask_readback_out[2]
    |-> ##[2:3] event_status_count_out) else $error("signal two event lost");
  chk_lost_stat: assert property (drop && event_mask_readback_out[0]
    |-> ##[1:4] event_status_count_out) else $error("reservation loss not flagged");
  chk_count_needs_mask: assert property ($rose(event_status_count_out)
    |-> $past(event_mask_readback_out) != 3'h0) else $error("count rose while masked");
  cover property (sig_one_wr_in && !v1_ff);
  cover property (drop);
  cover property (acc && pslverr_out);
endmodule // srev_top_chk

bind srev_top srev_top_chk u_chk (.*);

// >>> srev_far_agent.sv
// Far-side model: outside writers of the signal words, line snoops and the reserve command
`timescale 1ns/1ps
module srev_far_agent
(
  input  wire logic   mclk_in,
  output logic        sig_one_wr_out,
  output logic [31:0] sig_one_data_out,
  output logic        sig_two_wr_out,
  output logic [31:0] sig_two_data_out,
  output logic        reserve_out,
  output logic [24:0] reserve_line_out,
  output logic        snoop_mod_out,
  output logic [24:0] snoop_line_out
);
  initial
  begin
    {sig_one_wr_out, sig_two_wr_out, reserve_out, snoop_mod_out} = 4'h0;
    {sig_one_data_out, sig_two_data_out, reserve_line_out, snoop_line_out} = '0;
  end
  // Idle data lines show the inverse of the last value so stale words never match by luck
  task automatic signal(input logic two, input logic [31:0] d);
    sig_one_wr_out <= !two;
    sig_two_wr_out <= two;
    sig_one_data_out <= d;
    sig_two_data_out <= d;
    @(posedge mclk_in);
    sig_one_wr_out <= 1'b0;
    sig_two_wr_out <= 1'b0;
    sig_one_data_out <= ~d;
    sig_two_data_out <= ~d;
    @(posedge mclk_in);
  endtask
  task automatic reserve(input logic [24:0] l);
    reserve_out <= 1'b1;
    reserve_line_out <= l;
    @(posedge mclk_in);
    reserve_out <= 1'b0;
    reserve_line_out <= ~l;
    @(posedge mclk_in);
  endtask
  task automatic snoop(input logic [24:0] l);
    snoop_mod_out <= 1'b1;
    snoop_line_out <= l;
    @(posedge mclk_in);
    snoop_mod_out <= 1'b0;
    snoop_line_out <= ~l;
    @(posedge mclk_in);
  endtask
endmodule // srev_far_agent

// >>> srev_top_tb.sv
// Self-checking bench for the signal and reservation event block
`timescale 1ns/1ps
module srev_top_tb;
  logic        mclk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic [31:0] prdata_out, rd, m;
  logic        pready_out, pslverr_out, err, event_status_count_out, irq_out;
  logic        got_rdy;
  logic [2:0]  event_mask_readback_out;
  logic        sig_one_wr_in, sig_two_wr_in, reserve_in, snoop_mod_in;
  logic [31:0] sig_one_data_in, sig_two_data_in;
  logic [24:0] reserve_line_in, snoop_line_in;
  int          failures = 0;
  int          checks = 0;

  always #2 mclk_in = ~mclk_in;
  srev_top dut (.*);
  srev_far_agent far
  (
    .mclk_in          (mclk_in),
    .sig_one_wr_out   (sig_one_wr_in),
    .sig_one_data_out (sig_one_data_in),
    .sig_two_wr_out   (sig_two_wr_in),
    .sig_two_data_out (sig_two_data_in),
    .reserve_out      (reserve_in),
    .reserve_line_out (reserve_line_in),
    .snoop_mod_out    (snoop_mod_in),
    .snoop_line_out   (snoop_line_in)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    // Ready and read data are combinational from state that moves at the edge,
    // so they are sampled settled mid-cycle and taken at the closing rising edge
    do
    begin
      @(negedge mclk_in);
      got_rdy = pready_out;
      rd = prdata_out;
      err = pslverr_out;
      @(posedge mclk_in);
    end
    while (got_rdy !== 1'b1);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask

  task automatic t_reset;
    logic [11:0] offs [6] = '{12'h000, 12'h004, 12'h008, 12'h018, 12'h020, 12'h024};
    foreach (offs[k])
      rdchk(offs[k], 32'h0000_0000);
    chk(32'(event_status_count_out), 32'h0000_0000);
    $display("test reset done");
  endtask
  // Handler order: mask, acknowledge, read the word, restore the mask
  task automatic t_sig;
    for (int i = 1; i <= 2; i++)
    begin
      m = 32'h0000_0001 << i;
      apb(1'b1, 12'h004, 32'h0000_0007);
      far.signal(i == 2, 32'hA5C3_0000 | m);
      repeat (2) @(posedge mclk_in);
      rdchk(12'h000, m);
      rdchk(12'h008, 32'h8000_0000 | m);
      rdchk(12'h008, 32'h0000_0000);
      apb(1'b1, 12'h004, 32'h0000_0007 & ~m);
      apb(1'b1, 12'h00C, m);
      rdchk(12'h000, 32'h0000_0000);
      rdchk(i == 2 ? 12'h014 : 12'h010, 32'hA5C3_0000 | m);
      chk(32'(err), 32'h0000_0000);
      apb(1'b1, 12'h004, 32'h0000_0007);
      chk(32'(event_mask_readback_out), 32'h0000_0007);
    end
    $display("test signal events done");
  endtask
  task automatic t_masked;
    apb(1'b1, 12'h004, 32'h0000_0000);
    far.signal(1'b0, 32'h1357_9BDF);
    far.signal(1'b1, 32'h2468_ACE0);
    repeat (2) @(posedge mclk_in);
    rdchk(12'h000, 32'h0000_0006);
    rdchk(12'h008, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0004);
    rdchk(12'h000, 32'h0000_0004);
    apb(1'b1, 12'h00C, 32'h0000_0004);
    rdchk(12'h000, 32'h0000_0000);
    rdchk(12'h010, 32'h1357_9BDF);
    rdchk(12'h014, 32'h2468_ACE0);
    $display("test masked events done");
  endtask
  task automatic t_resv;
    apb(1'b1, 12'h004, 32'h0000_0001);
    far.reserve(25'h000_1234);
    rdchk(12'h018, 32'h8000_1234);
    far.snoop(25'h000_1235);
    repeat (2) @(posedge mclk_in);
    rdchk(12'h000, 32'h0000_0000);
    far.snoop(25'h000_1234);
    repeat (2) @(posedge mclk_in);
    rdchk(12'h000, 32'h0000_0001);
    rdchk(12'h008, 32'h8000_0001);
    apb(1'b1, 12'h00C, 32'h0000_0001);
    far.reserve(25'h000_1234);
    apb(1'b1, 12'h01C, 32'h0000_0001);
    repeat (2) @(posedge mclk_in);
    rdchk(12'h000, 32'h0000_0001);
    apb(1'b0, 12'h018, 32'h0000_0000);
    chk(32'(rd[31]), 32'h0000_0000);
    $display("test reservation done");
  endtask
  task automatic t_irq;
    rdchk(12'h020, 32'h0000_0007);
    apb(1'b1, 12'h024, 32'h0000_0002);
    far.signal(1'b1, 32'h0F0F_0F0F);
    repeat (2) @(posedge mclk_in);
    chk(32'(irq_out), 32'h0000_0000);
    far.signal(1'b0, 32'hF0F0_F0F0);
    repeat (2) @(posedge mclk_in);
    chk(32'(irq_out), 32'h0000_0001);
    rdchk(12'h020, 32'h0000_0006);
    chk(32'(irq_out), 32'h0000_0000);
    apb(1'b1, 12'h00C, 32'h0000_0007);
    rdchk(12'h000, 32'h0000_0000);
    rdchk(12'h030, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    $display("test interrupt and refusal done");
  endtask

  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Tests need under 1000 cycles, so 40 us means a hang
  initial
  begin
    #40000;
    failures++;
    close_out();
  end
  initial
  begin
    repeat (8) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
    t_reset();
    t_sig();
    t_masked();
    t_resv();
    t_irq();
    close_out();
  end
endmodule // srev_top_tb
